// >>> include/shcp_cfg.svh
// shcp_cfg.svh: register offsets, field positions, reset values, mode codes
// and divider counts of the byte-wide serial port.
// assumes: included by bare name, clock at 10 MHz (100 ns period).
`ifndef SHCP_CFG_SVH
`define SHCP_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// register offsets on the plain register port
`define SHCP_OFS_CTRL1   3'h0
`define SHCP_OFS_STATUS  3'h1
`define SHCP_OFS_BUF     3'h2
`define SHCP_OFS_RELOAD  3'h3
`define SHCP_OFS_CTRL3   3'h4
`define SHCP_OFS_IRQ     3'h5

////////////////////////////////////////////////////////////////////////////
// field positions
`define SHCP_C1_WRITE_COLLISION     7
`define SHCP_C1_EN       5
`define SHCP_C1_CPOL     4
`define SHCP_C1_MODE     3:0
`define SHCP_ST_SMP      7
`define SHCP_ST_CKE      6
`define SHCP_ST_BUSY     2
`define SHCP_ST_BF       0
`define SHCP_C3_BUFFER_OVERWRITE_ENABLE     4
`define SHCP_C3_SDOD     1
`define SHCP_C3_WAKE     0
`define SHCP_IRQ_FLAG    0

////////////////////////////////////////////////////////////////////////////
// reset values
`define SHCP_RST_BYTE    8'h00
`define SHCP_RST_MODE    4'h0
`define SHCP_RST_BIT     1'b0

////////////////////////////////////////////////////////////////////////////
// mode field codes
`define SHCP_MODE_DIV4   4'h0
`define SHCP_MODE_DIV16  4'h1
`define SHCP_MODE_DIV64  4'h2
`define SHCP_MODE_TMR    4'h3
`define SHCP_MODE_CL_SS  4'h4
`define SHCP_MODE_CL     4'h5
`define SHCP_MODE_RELOAD 4'hA

////////////////////////////////////////////////////////////////////////////
// timing: last cycle of each sck half period (half period = value + 1), then last half period and last bit indexes
`define SHCP_HALF_DIV4   9'h001
`define SHCP_HALF_DIV16  9'h007
`define SHCP_HALF_DIV64  9'h01F
`define SHCP_LAST_HALF   4'hF
`define SHCP_LAST_BIT    3'h7

`endif

// >>> include/shcp_pkg.sv
// shcp_pkg: types shared by the serial port modules.
// assumes: compiled before every file of core/.
package shcp_pkg;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SHIFT = 2'b01,
    HS_DONE  = 2'b11
  } shcp_hstate_t;

  typedef enum logic [2:0] {
    RATE_DIV4   = 3'h0,
    RATE_DIV16  = 3'h1,
    RATE_DIV64  = 3'h2,
    RATE_TMR    = 3'h3,
    RATE_RELOAD = 3'h4
  } shcp_rate_t;

endpackage : shcp_pkg

// >>> core/shcp_edge.sv
// shcp_edge: rising and falling edge detector for one input.
// assumes: input already synchronous to clk.
module shcp_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // signal
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);
  import shcp_pkg::*;

  logic prev_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prev_reg <= 1'b0;
    else
      prev_reg <= sig;
  end

  assign rise = sig & ~prev_reg;
  assign fall = ~sig & prev_reg;

endmodule : shcp_edge

// >>> core/shcp_rate_gen.sv
// shcp_rate_gen: half-bit tick generator for host mode sck.
// assumes: clr while no byte is shifting, hold while the device sleeps.
`include "shcp_cfg.svh"
module shcp_rate_gen (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // control
  input  wire logic              clr,
  input  wire logic              hold,
  input  wire shcp_pkg::shcp_rate_t sel,
  input  wire logic [7:0]        reload,
  input  wire logic              timer_rise,
  // tick
  output logic                   tick
);
  import shcp_pkg::*;

  logic [8:0] cnt_reg;
  logic [8:0] lim;

  // reload rate is clk / (4 * (reload + 1)), so half period 2 * (reload + 1)
  always_comb
  begin
    lim = `SHCP_HALF_DIV4;
    case (sel)
      RATE_DIV16:  lim = `SHCP_HALF_DIV16;
      RATE_DIV64:  lim = `SHCP_HALF_DIV64;
      RATE_RELOAD: lim = {reload, 1'b1};
      default:     lim = `SHCP_HALF_DIV4;
    endcase
  end

  // hold freezes the count in place so a slept transfer resumes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= 9'h000;
      tick    <= 1'b0;
    end
    else if (clr)
    begin
      cnt_reg <= 9'h000;
      tick    <= 1'b0;
    end
    else if (hold)
      tick <= 1'b0;
    else if (sel == RATE_TMR)
      tick <= timer_rise;
    else if (cnt_reg >= lim)
    begin
      cnt_reg <= 9'h000;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 9'h001;
      tick    <= 1'b0;
    end
  end

endmodule : shcp_rate_gen

// >>> core/shcp_top.sv
// shcp_top: byte-wide serial port, host or client, with register port.
// assumes: all inputs synchronous to clk; pad logic resolves pin levels
// from the output enables.
`include "shcp_cfg.svh"
module shcp_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // serial pins
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       sdi,
  output logic            sdo_out,
  output logic            sdo_oe,
  input  wire logic       ss_n,
  // system
  input  wire logic       sleep,
  input  wire logic       periodic_timer_output,
  output logic            serial_port_irq_flag,
  output logic            wake_req
);
  import shcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // software state
  logic         write_collision_reg;
  logic         port_enable_reg;
  logic         clock_idle_polarity_reg;
  logic [3:0]   mode_reg;
  logic         sample_phase_reg;
  logic         edge_select_reg;
  logic         buffer_full_reg;
  logic         buffer_overwrite_enable_reg;
  logic         sdo_disable_reg;
  logic         wake_enable_reg;
  logic [7:0]   rate_reload_value_reg;
  logic [7:0]   transfer_buffer_reg;

  // datapath state
  logic [7:0]   shift_register_reg;
  logic         out_bit_reg;
  shcp_hstate_t hstate_reg;
  logic [3:0]   half_cnt_reg;
  logic [2:0]   bit_cnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic       is_host;
  logic       is_client;
  logic       ss_ctl;
  logic       client_act;
  logic       busy;
  logic       wr_buf;
  logic       rd_buf;
  logic       wr_ok;
  logic       host_start;
  logic       tick;
  logic       sck_rise;
  logic       sck_fall;
  logic       ss_fall;
  logic       tmr_rise;
  logic       lead_ev;
  logic       trail_ev;
  logic       samp_ev;
  logic       out_ev;
  logic       host_done;
  logic       client_done;
  logic [7:0] rx_next;
  logic [7:0] rd_val;
  shcp_rate_t rate_sel;

  assign is_host = port_enable_reg &
                   ((mode_reg == `SHCP_MODE_DIV4)  |
                    (mode_reg == `SHCP_MODE_DIV16) |
                    (mode_reg == `SHCP_MODE_DIV64) |
                    (mode_reg == `SHCP_MODE_TMR)   |
                    (mode_reg == `SHCP_MODE_RELOAD));
  assign ss_ctl    = (mode_reg == `SHCP_MODE_CL_SS);
  assign is_client = port_enable_reg &
                     (ss_ctl | (mode_reg == `SHCP_MODE_CL));
  // with select control, a high select holds the client in reset
  assign client_act = is_client & ~(ss_ctl & ss_n);

  assign busy   = (hstate_reg != HS_IDLE) | (bit_cnt_reg != 3'h0);
  assign wr_buf = reg_wr & (reg_addr == `SHCP_OFS_BUF);
  assign rd_buf = reg_rd & (reg_addr == `SHCP_OFS_BUF);
  // unread byte blocks the write unless overwrite is enabled
  assign wr_ok  = wr_buf & ~busy &
                  (~buffer_full_reg | buffer_overwrite_enable_reg);
  assign host_start = wr_ok & is_host;

  always_comb
  begin
    rate_sel = RATE_DIV4;
    case (mode_reg)
      `SHCP_MODE_DIV16:  rate_sel = RATE_DIV16;
      `SHCP_MODE_DIV64:  rate_sel = RATE_DIV64;
      `SHCP_MODE_TMR:    rate_sel = RATE_TMR;
      `SHCP_MODE_RELOAD: rate_sel = RATE_RELOAD;
      default:           rate_sel = RATE_DIV4;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // submodules
  shcp_edge u_sck_edge (
    .clk  (clk),
    .rstn (rstn),
    .sig  (sck_in),
    .rise (sck_rise),
    .fall (sck_fall)
  );

  shcp_edge u_ss_edge (
    .clk  (clk),
    .rstn (rstn),
    .sig  (ss_n),
    .rise (),
    .fall (ss_fall)
  );

  shcp_edge u_tmr_edge (
    .clk  (clk),
    .rstn (rstn),
    .sig  (periodic_timer_output),
    .rise (tmr_rise),
    .fall ()
  );

  // sleep stops the host ticks only; the client keeps shifting
  shcp_rate_gen u_rate (
    .clk        (clk),
    .rstn       (rstn),
    .clr        (hstate_reg != HS_SHIFT),
    .hold       (sleep),
    .sel        (rate_sel),
    .reload     (rate_reload_value_reg),
    .timer_rise (tmr_rise),
    .tick       (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // edge events: leading edge leaves the idle level
  always_comb
  begin
    lead_ev  = 1'b0;
    trail_ev = 1'b0;
    if (is_host)
    begin
      lead_ev  = tick & (hstate_reg == HS_SHIFT) & ~half_cnt_reg[0];
      trail_ev = tick & (hstate_reg == HS_SHIFT) & half_cnt_reg[0];
    end
    else if (client_act)
    begin
      lead_ev  = clock_idle_polarity_reg ? sck_fall : sck_rise;
      trail_ev = clock_idle_polarity_reg ? sck_rise : sck_fall;
    end
  end

  // edge select set: sample on leading edge, output on trailing edge
  assign samp_ev = edge_select_reg ? lead_ev : trail_ev;
  assign out_ev  = edge_select_reg ? trail_ev : lead_ev;
  assign rx_next = {shift_register_reg[6:0], sdi};

  assign host_done   = (hstate_reg == HS_DONE);
  assign client_done = client_act & samp_ev &
                       (bit_cnt_reg == `SHCP_LAST_BIT);

  ////////////////////////////////////////////////////////////////////////
  // host sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hstate_reg   <= HS_IDLE;
      half_cnt_reg <= 4'h0;
    end
    else if (!is_host)
    begin
      hstate_reg   <= HS_IDLE;
      half_cnt_reg <= 4'h0;
    end
    else
    begin
      case (hstate_reg)
        HS_IDLE:
          if (host_start)
          begin
            hstate_reg   <= HS_SHIFT;
            half_cnt_reg <= 4'h0;
          end
        HS_SHIFT:
          if (tick)
          begin
            half_cnt_reg <= half_cnt_reg + 4'h1;
            if (half_cnt_reg == `SHCP_LAST_HALF)
              hstate_reg <= HS_DONE;
          end
        HS_DONE:
          hstate_reg <= HS_IDLE;
        default:
          hstate_reg <= HS_IDLE;
      endcase
    end
  end

  // sck toggles once per tick, sixteen half periods back to idle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end
    else
    begin
      sck_oe <= is_host;
      if ((hstate_reg == HS_SHIFT) && tick)
        sck_out <= ~sck_out;
      else if (hstate_reg != HS_SHIFT)
        sck_out <= clock_idle_polarity_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // client bit counter
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bit_cnt_reg <= 3'h0;
    else if (!client_act)
      bit_cnt_reg <= 3'h0;
    else if (ss_ctl && ss_fall)
      bit_cnt_reg <= 3'h0;
    else if (samp_ev)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // shift register and serial output bit
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      shift_register_reg <= `SHCP_RST_BYTE;
    else if (wr_ok)
      shift_register_reg <= reg_wdata;
    else if (samp_ev)
      shift_register_reg <= rx_next;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_bit_reg <= 1'b0;
    else if (wr_ok && edge_select_reg)
      out_bit_reg <= reg_wdata[7];
    else if (ss_ctl && ss_fall && edge_select_reg)
      out_bit_reg <= shift_register_reg[7];
    else if (out_ev)
      out_bit_reg <= shift_register_reg[7];
  end

  // a disabled sdo still leaves shifting running, for receive-only use
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
    end
    else
    begin
      sdo_out <= (wr_ok && edge_select_reg) ? reg_wdata[7] : out_bit_reg;
      sdo_oe  <= ~sdo_disable_reg & (is_host | client_act);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer buffer and status flags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      transfer_buffer_reg <= `SHCP_RST_BYTE;
    else if (host_done)
      transfer_buffer_reg <= shift_register_reg;
    else if (client_done)
      transfer_buffer_reg <= rx_next;
    else if (wr_ok)
      transfer_buffer_reg <= reg_wdata;
  end

  // set wins over a clear in the same cycle for every flag below
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      buffer_full_reg <= `SHCP_RST_BIT;
    else if (host_done || client_done)
      buffer_full_reg <= 1'b1;
    else if (rd_buf)
      buffer_full_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      serial_port_irq_flag <= `SHCP_RST_BIT;
    else if (host_done || client_done)
      serial_port_irq_flag <= 1'b1;
    else if (reg_wr && (reg_addr == `SHCP_OFS_IRQ) &&
             !reg_wdata[`SHCP_IRQ_FLAG])
      serial_port_irq_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      write_collision_reg <= `SHCP_RST_BIT;
    else if (wr_buf && busy)
      write_collision_reg <= 1'b1;
    else if (reg_wr && (reg_addr == `SHCP_OFS_CTRL1) &&
             !reg_wdata[`SHCP_C1_WRITE_COLLISION])
      write_collision_reg <= 1'b0;
  end

  // wake request holds until the device leaves sleep
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wake_req <= 1'b0;
    else if (client_done && sleep && wake_enable_reg)
      wake_req <= 1'b1;
    else if (!sleep)
      wake_req <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration writes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_enable_reg             <= `SHCP_RST_BIT;
      clock_idle_polarity_reg     <= `SHCP_RST_BIT;
      mode_reg                    <= `SHCP_RST_MODE;
      sample_phase_reg            <= `SHCP_RST_BIT;
      edge_select_reg             <= `SHCP_RST_BIT;
      buffer_overwrite_enable_reg <= `SHCP_RST_BIT;
      sdo_disable_reg             <= `SHCP_RST_BIT;
      wake_enable_reg             <= `SHCP_RST_BIT;
      rate_reload_value_reg       <= `SHCP_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `SHCP_OFS_CTRL1)
      begin
        port_enable_reg         <= reg_wdata[`SHCP_C1_EN];
        clock_idle_polarity_reg <= reg_wdata[`SHCP_C1_CPOL];
        mode_reg                <= reg_wdata[`SHCP_C1_MODE];
      end
      else if (reg_addr == `SHCP_OFS_STATUS)
      begin
        sample_phase_reg <= reg_wdata[`SHCP_ST_SMP];
        edge_select_reg  <= reg_wdata[`SHCP_ST_CKE];
      end
      else if (reg_addr == `SHCP_OFS_RELOAD)
        rate_reload_value_reg <= reg_wdata;
      else if (reg_addr == `SHCP_OFS_CTRL3)
      begin
        buffer_overwrite_enable_reg <= reg_wdata[`SHCP_C3_BUFFER_OVERWRITE_ENABLE];
        sdo_disable_reg             <= reg_wdata[`SHCP_C3_SDOD];
        wake_enable_reg             <= reg_wdata[`SHCP_C3_WAKE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: data in the cycle after the strobe, zero otherwise
  always_comb
  begin
    rd_val = 8'h00;
    if (reg_addr == `SHCP_OFS_CTRL1)
    begin
      rd_val[`SHCP_C1_WRITE_COLLISION] = write_collision_reg;
      rd_val[`SHCP_C1_EN]   = port_enable_reg;
      rd_val[`SHCP_C1_CPOL] = clock_idle_polarity_reg;
      rd_val[`SHCP_C1_MODE] = mode_reg;
    end
    else if (reg_addr == `SHCP_OFS_STATUS)
    begin
      rd_val[`SHCP_ST_SMP]  = sample_phase_reg;
      rd_val[`SHCP_ST_CKE]  = edge_select_reg;
      rd_val[`SHCP_ST_BUSY] = busy;
      rd_val[`SHCP_ST_BF]   = buffer_full_reg;
    end
    else if (reg_addr == `SHCP_OFS_BUF)
      rd_val = transfer_buffer_reg;
    else if (reg_addr == `SHCP_OFS_RELOAD)
      rd_val = rate_reload_value_reg;
    else if (reg_addr == `SHCP_OFS_CTRL3)
    begin
      rd_val[`SHCP_C3_BUFFER_OVERWRITE_ENABLE] = buffer_overwrite_enable_reg;
      rd_val[`SHCP_C3_SDOD] = sdo_disable_reg;
      rd_val[`SHCP_C3_WAKE] = wake_enable_reg;
    end
    else if (reg_addr == `SHCP_OFS_IRQ)
      rd_val[`SHCP_IRQ_FLAG] = serial_port_irq_flag;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_val : 8'h00;
  end

endmodule : shcp_top

// >>> tb/shcp_properties.sv
// shcp_properties: port-level checks on the serial port top.
// assumes: bound into shcp_top; one clock, rstn async active low.
`include "shcp_cfg.svh"
module shcp_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and system
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       sdo_oe,
  input wire logic       ss_n,
  input wire logic       sleep,
  input wire logic       serial_port_irq_flag,
  input wire logic       wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  a_unmapped_zero: assert property (
    reg_rd && reg_addr[2:1] == 2'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_status_spare: assert property (
    reg_rd && reg_addr == `SHCP_OFS_STATUS
    |=> reg_rdata[5:3] == 3'h0 && !reg_rdata[1])
    else $error("status spare bits set");
  a_irq_sticky: assert property (
    serial_port_irq_flag && !(reg_wr && reg_addr == `SHCP_OFS_IRQ)
    |=> serial_port_irq_flag)
    else $error("irq flag dropped by itself");
  a_sck_half_min: assert property (
    sck_oe && $changed(sck_out) |=> $stable(sck_out))
    else $error("sck half period under two cycles");
  // a tick issued just before sleep lands may still toggle once
  a_sleep_freeze: assert property (
    sleep && $past(sleep) && $past(sleep, 2) && sck_oe |-> $stable(sck_out))
    else $error("host sck moved in sleep");
  a_ss_release: assert property (
    $rose(ss_n) && !sck_oe |=> !sdo_oe)
    else $error("sdo still driven after deselect");
  a_wake_cause: assert property (
    $rose(wake_req) |-> $past(sleep))
    else $error("wake request while awake");
  a_wake_clear: assert property (
    !sleep && !$past(sleep) |-> !wake_req)
    else $error("wake request not cleared");
endmodule : shcp_properties

bind shcp_top shcp_properties u_props (
  .clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .sck_out,
  .sck_oe, .sdo_oe, .ss_n, .sleep, .serial_port_irq_flag, .wake_req
);

// >>> tb/shcp_far_end.sv
// shcp_far_end: spi client facing the host-mode port, either idle level,
// samples on rising sck and shifts on falling sck.
// assumes: load pulses only while sck is idle.
module shcp_far_end (
  // pins
  input  wire logic       sck,
  input  wire logic       sdo,
  output logic            sdi,
  // stimulus
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_reg = 8'h00;
  initial rx_byte = 8'h00;
  assign sdi = sh_reg[7];
  always @(posedge load)
    sh_reg = tx_byte;
  // inverted fill: after the byte the line keeps moving, never stale
  always @(negedge sck)
    sh_reg = {sh_reg[6:0], ~sh_reg[0]};
  always @(posedge sck)
    rx_byte = {rx_byte[6:0], sdo};
endmodule : shcp_far_end

// >>> tb/test_shcp_top.sv
// test_shcp_top: scenarios through register port and serial pins.
// assumes: far-end model and checker compiled before this file.
`include "shcp_cfg.svh"
module test_shcp_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, tx_byte = 8'h00, reg_rdata, rx_byte;
  logic       sck_c = 1'b0, sdi_c = 1'b0, ss_n = 1'b1, sleep = 1'b0;
  logic       tmr = 1'b0, load = 1'b0, sdo_last = 1'b0;
  logic       sck_out, sck_oe, sdo_out, sdo_oe, irq, wake_req, sdi_f;
  int         bad_count = 0, check_count = 0, cyc = 0, rises = 0;
  time        t_prev = 0, per = 0;
  wire        sdi = sck_oe ? sdi_f : sdi_c;
  wire        sdo_w = sdo_oe ? sdo_out : ~sdo_last;
  shcp_top DUT (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sck_in(sck_c), .sck_out, .sck_oe, .sdi, .sdo_out, .sdo_oe, .ss_n,
    .sleep, .periodic_timer_output(tmr), .serial_port_irq_flag(irq),
    .wake_req);
  shcp_far_end u_far (
    .sck(sck_out), .sdo(sdo_w), .sdi(sdi_f), .load, .tx_byte, .rx_byte);
  ////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  always @(posedge sck_out)
  begin
    per = $time - t_prev;
    t_prev = $time;
    rises++;
  end
  // timer rises every 6 cycles, so timer mode has a 12-cycle bit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2)
      tmr <= ~tmr;
    if (sdo_oe)
      sdo_last <= sdo_out;
    if (cyc > 40000)
    begin
      bad_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chk(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_irq(input int lim);
    int n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk("irq", 8'h01, {7'h0, irq});
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] v;
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), v);
      chk("reset value", 8'h00, v);
    end
    wr(3'h7, 8'hFF);
    rd(3'h7, v);
    chk("unmapped", 8'h00, v);
  endtask : t_reset
  task automatic t_host(input logic [3:0] m, input int hp,
                        input logic [7:0] tx, input logic ro);
    logic [7:0] v;
    tx_byte <= ~tx;
    load <= 1'b1;
    wr(`SHCP_OFS_CTRL1, {4'h2, m});
    load <= 1'b0;
    rises = 0;
    wr(`SHCP_OFS_BUF, tx);
    wait_irq(40 * hp);
    chk("pulses", 8'h08, 8'(rises));
    chk("period", 8'(2 * hp), 8'(per / 100));
    chk("sck idle", 8'h00, {7'h0, sck_out});
    chk("sck drive", 8'h01, {7'h0, sck_oe});
    chk("sdo drive", {7'h0, ~ro}, {7'h0, sdo_oe});
    if (!ro)
      chk("far rx", tx, rx_byte);
    rd(`SHCP_OFS_BUF, v);
    chk("rx byte", ~tx, v);
    rd(`SHCP_OFS_STATUS, v);
    chk("status", 8'h40, v);
    wr(`SHCP_OFS_IRQ, 8'h00);
  endtask : t_host
  task automatic t_modes();
    logic [3:0] m [5] = '{`SHCP_MODE_DIV4, `SHCP_MODE_DIV16,
      `SHCP_MODE_DIV64, `SHCP_MODE_TMR, `SHCP_MODE_RELOAD};
    int h [5] = '{2, 8, 32, 6, 6};
    wr(`SHCP_OFS_RELOAD, 8'h02);
    wr(`SHCP_OFS_STATUS, 8'h40);
    for (int i = 0; i < 5; i++)
      t_host(m[i], h[i], 8'hA5 ^ 8'(i * 27), 1'b0);
    wr(`SHCP_OFS_CTRL3, 8'h02);
    t_host(`SHCP_MODE_DIV4, 2, 8'h3C, 1'b1);
    wr(`SHCP_OFS_CTRL3, 8'h00);
  endtask : t_modes
  task automatic t_coll();
    logic [7:0] v;
    wr(`SHCP_OFS_CTRL1, 8'h22);
    wr(`SHCP_OFS_BUF, 8'h81);
    wr(`SHCP_OFS_BUF, 8'h7E);
    rd(`SHCP_OFS_CTRL1, v);
    chk("collision", 8'hA2, v);
    wr(`SHCP_OFS_CTRL1, 8'h22);
    wait_irq(2000);
    chk("kept byte", 8'h81, rx_byte);
    wr(`SHCP_OFS_IRQ, 8'h00);
    wr(`SHCP_OFS_BUF, 8'h55);
    rd(`SHCP_OFS_STATUS, v);
    chk("unread refused", 8'h41, v);
    wr(`SHCP_OFS_CTRL3, 8'h10);
    wr(`SHCP_OFS_BUF, 8'h55);
    rd(`SHCP_OFS_STATUS, v);
    chk("overwrite", 8'h45, v);
    wait_irq(2000);
    rd(`SHCP_OFS_BUF, v);
    wr(`SHCP_OFS_CTRL3, 8'h00);
    wr(`SHCP_OFS_IRQ, 8'h00);
  endtask : t_coll
  task automatic t_sleep();
    logic [7:0] v;
    int r;
    wr(`SHCP_OFS_CTRL1, 8'h31);
    wr(`SHCP_OFS_BUF, 8'h96);
    repeat (30) @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    #1 r = rises;
    repeat (60) @(posedge clk);
    chk("frozen", 8'(r), 8'(rises));
    sleep <= 1'b0;
    wait_irq(400);
    chk("resumed", 8'h96, rx_byte);
    chk("sck idle high", 8'h01, {7'h0, sck_out});
    rd(`SHCP_OFS_BUF, v);
    wr(`SHCP_OFS_IRQ, 8'h00);
  endtask : t_sleep
  // plays the external host: 4-cycle half periods, well under clk/2
  task automatic cbyte(input logic [7:0] d, input int n,
                       output logic [7:0] g);
    for (int i = 7; i > 7 - n; i--)
    begin
      @(posedge clk);
      sdi_c <= d[i];
      repeat (3) @(posedge clk);
      g[i] = sdo_out;
      sck_c <= 1'b1;
      repeat (4) @(posedge clk);
      sck_c <= 1'b0;
      sdi_c <= ~d[i];
    end
  endtask : cbyte
  task automatic t_client();
    logic [7:0] g, v;
    wr(`SHCP_OFS_CTRL1, 8'h24);
    wr(`SHCP_OFS_BUF, 8'hB4);
    ss_n <= 1'b0;
    cbyte(8'h6D, 8, g);
    chk("client tx", 8'hB4, g);
    chk("client irq", 8'h01, {7'h0, irq});
    chk("sck free", 8'h00, {7'h0, sck_oe});
    rd(`SHCP_OFS_BUF, v);
    chk("client rx", 8'h6D, v);
    wr(`SHCP_OFS_IRQ, 8'h00);
    cbyte(8'hF0, 3, g);
    ss_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("sdo free", 8'h00, {7'h0, sdo_oe});
    rd(`SHCP_OFS_STATUS, v);
    chk("bits cleared", 8'h40, v);
    wr(`SHCP_OFS_CTRL3, 8'h01);
    sleep <= 1'b1;
    ss_n <= 1'b0;
    cbyte(8'h2A, 8, g);
    chk("wake", 8'h01, {7'h0, wake_req});
    sleep <= 1'b0;
    rd(`SHCP_OFS_BUF, v);
    chk("aligned rx", 8'h2A, v);
    chk("wake off", 8'h00, {7'h0, wake_req});
    ss_n <= 1'b1;
  endtask : t_client
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_modes();
    t_coll();
    t_sleep();
    t_client();
    stop_test();
  end
endmodule : test_shcp_top
